// >>> dv/gige_regs_properties.sv
// port assertions for the gigabit status and indirect access register block
`timescale 1ns/1ps
module gige_regs_properties
    import gige_mgmt_pkg::*;
(
    input wire logic sys_clk,            // system clock
    input wire logic resetn,             // async reset, active low
    input wire logic mdc,                // management clock
    input wire logic mdio_i,             // management data in
    input wire logic mdio_o,             // management data out
    input wire logic mdio_oe,            // drive enable
    input wire logic [4:0] phy_addr,     // station address
    input wire phy_status_t phy_status,  // line side status
    input wire mmd_req_t mmd_req,        // request to the mmds
    input wire logic [15:0] mmd_rdata    // mmd content
);
    logic mdc_d_r;
    logic [7:0] mdc_age_r;
    logic [7:0] oe_cnt_r;

    // age saturates so a long idle gap never wraps back into the window
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mdc_d_r <= 1'b0;
            mdc_age_r <= 8'hff;
        end else begin
            mdc_d_r <= mdc;
            if (mdc && !mdc_d_r) begin
                mdc_age_r <= 8'h00;
            end else if (mdc_age_r != 8'hff) begin
                mdc_age_r <= mdc_age_r + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            oe_cnt_r <= 8'h00;
        end else if (!mdio_oe) begin
            oe_cnt_r <= 8'h00;
        end else if (oe_cnt_r != 8'hff) begin
            oe_cnt_r <= oe_cnt_r + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence mdc_fresh;
        mdc_age_r inside {[1:8]};
    endsequence
    sequence answer_open;
        $rose(mdio_oe) ##0 !mdio_o;
    endsequence

    rd_single_a: assert property (mmd_req.rd |=> !mmd_req.rd)
        else $error("mmd read pulse longer than one cycle");
    wr_single_a: assert property (mmd_req.wr |=> !mmd_req.wr)
        else $error("mmd write pulse longer than one cycle");
    req_excl_a: assert property (!(mmd_req.rd && mmd_req.wr))
        else $error("mmd read and write together");
    rd_answer_a: assert property (mmd_req.rd |-> ##[0:8] mdio_oe)
        else $error("mmd read outside a read answer");
    wr_quiet_a: assert property (mmd_req.wr |-> !mdio_oe)
        else $error("mmd write during a read answer");
    answer_len_a: assert property ($fell(mdio_oe) |-> oe_cnt_r inside {[128:144]})
        else $error("read answer not seventeen link periods long");
    ta_drive_a: assert property (answer_open |-> mdc_fresh)
        else $error("answer start not tied to a link clock edge");
    wr_timing_a: assert property (mmd_req.wr |-> mdc_fresh)
        else $error("mmd write not tied to a link clock edge");
endmodule : gige_regs_properties

bind gige_status_mmd_access_regs gige_regs_properties u_props (.sys_clk(sys_clk),
    .resetn(resetn), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .phy_addr(phy_addr), .phy_status(phy_status), .mmd_req(mmd_req), .mmd_rdata(mmd_rdata));

// >>> dv/mdio_station.sv
// station management model driving whole frames on the pulled-up management line
`timescale 1ns/1ps
module mdio_station
    import gige_mgmt_pkg::*;
(
    output logic mdc,         // management clock, low between frames
    output logic mdio_i,      // resolved line as the device sees it
    input wire logic mdio_o,  // device data
    input wire logic mdio_oe  // device drive enable
);
    logic st_en;
    logic st_d;

    // pull-up: a line nobody drives reads one
    assign mdio_i = mdio_oe ? mdio_o : (st_en ? st_d : 1'b1);

    initial begin
        mdc = 1'b0;
        st_en = 1'b0;
        st_d = 1'b1;
    end

    // bits change while mdc is low; the idle tail lets the device release the line
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] fr;
        fr = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            st_en = (op != OPCODE_READ) || (i > 17);
            st_d = fr[i];
            #80;
            mdc = 1'b1;
            if (i < 16) begin
                rd[i] = mdio_i;
            end
            #80;
            mdc = 1'b0;
        end
        st_en = 1'b0;
        #320;
    endtask : xfer
endmodule : mdio_station

// >>> dv/testbench.sv
// self-checking bench for the gigabit status and indirect access registers
`timescale 1ns/1ps
module testbench;
    import gige_mgmt_pkg::*;
    localparam logic [4:0] RG [6] = '{REG_GIGABIT_LINK_STATUS, REG_RSVD_POWER_CTRL,
        REG_RSVD_POWER_STATUS, REG_INDIRECT_CONTROL, REG_INDIRECT_WINDOW, REG_EXT_CAPABILITY};
    localparam logic [15:0] RV [6] = '{GIGABIT_LINK_STATUS_RST, RSVD_POWER_RST,
        RSVD_POWER_RST, INDIRECT_CONTROL_RST, INDIRECT_WINDOW_RST, EXT_CAPABILITY_RST};
    logic sys_clk, resetn, mdc, mdio_i, mdio_o, mdio_oe;
    logic [4:0] pa;
    phy_status_t ps;
    mmd_req_t mmd_req;
    logic [15:0] mmd_rdata, v, wd_seen;
    logic [20:0] rd_seen, wr_seen;
    int n_mismatch, n_tests;

    gige_status_mmd_access_regs uut (.sys_clk(sys_clk), .resetn(resetn), .mdc(mdc),
        .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr(pa),
        .phy_status(ps), .mmd_req(mmd_req), .mmd_rdata(mmd_rdata));
    mdio_station u_sta (.mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));

    function automatic logic [15:0] mmd_val(input logic [4:0] d, input logic [15:0] a);
        return {a[10:0], d} ^ 16'h5a3c;
    endfunction : mmd_val

    function automatic logic [15:0] gigabit_link_status(input logic f, input logic [7:0] c);
        return {f, ps.ms_is_master, ps.local_rx_ok, ps.remote_rx_ok, ps.partner_fd,
            ps.partner_hd, 2'b00, c};
    endfunction : gigabit_link_status

    assign mmd_rdata = mmd_val(mmd_req.dev, mmd_req.addr);

    always @(posedge sys_clk) begin
        if (mmd_req.rd) begin
            rd_seen = {mmd_req.dev, mmd_req.addr};
        end
        if (mmd_req.wr) begin
            wr_seen = {mmd_req.dev, mmd_req.addr};
            wd_seen = mmd_req.wdata;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            n_mismatch++;
        end
    endtask : check

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] unused;
        u_sta.xfer(OPCODE_WRITE, pa, ra, d, unused);
    endtask : wr

    task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
        u_sta.xfer(OPCODE_READ, pa, ra, 16'h0000, v);
        check({16'h0000, v}, {16'h0000, exp});
    endtask : rchk

    task automatic pulse(input logic [11:0] m, input int n);
        repeat (n) begin
            @(negedge sys_clk);
            ps = phy_status_t'(ps | m);
            @(negedge sys_clk);
            ps = phy_status_t'(ps & ~m);
        end
    endtask : pulse

    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // about sixty frames of some ten microseconds each, with margin
    initial begin
        #1_000_000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        logic [4:0] d, d2;
        logic [15:0] a, b, w;
        int n;
        n_mismatch = 0;
        n_tests = 0;
        ps = phy_status_t'(12'h000);
        resetn = 1'b0;
        void'($urandom(24));
        pa = 5'($urandom);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        wr(REG_EXT_CAPABILITY, 16'hffff);
        wr(REG_RSVD_POWER_CTRL, 16'h0000);
        wr(REG_RSVD_POWER_STATUS, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            rchk(RG[i], RV[i]);
        end
        rchk(5'h09, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            ps = phy_status_t'({3'b000, (i == 0) ? 5'h1f : 5'($urandom), 4'h0});
            rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'h00));
        end
        pulse(12'h800, 6);
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'h00));
        pulse(12'h800, 1);
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b1, 8'h00));
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'h00));
        for (int i = 0; i < 2; i++) begin
            pulse(12'h800, 7);
            pulse((i == 0) ? 12'h400 : 12'h200, 1);
            rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'h00));
        end
        ps = phy_status_t'(ps | 12'h00c);
        n = 1 + int'($urandom % 20);
        pulse(12'h002, n);
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'(n)));
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'h00));
        pulse(12'h002, 3);
        pulse(12'h001, 1);
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'h00));
        pulse(12'h002, 260);
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, IDLE_ERR_MAX));
        ps = phy_status_t'(ps & ~12'h004);
        pulse(12'h002, 5);
        rchk(REG_GIGABIT_LINK_STATUS, gigabit_link_status(1'b0, 8'h00));
        d2 = 5'($urandom);
        d = d2 ^ 5'h15;
        b = 16'($urandom);
        wr(REG_INDIRECT_CONTROL, {ACC_ADDRESS, 9'h000, d2});
        wr(REG_INDIRECT_WINDOW, b);
        for (int t = 1; t < 4; t++) begin
            a = (t == 1) ? 16'hffff : (16'($urandom) & 16'hfff0);
            w = 16'($urandom);
            wr(REG_INDIRECT_CONTROL, {ACC_ADDRESS, 9'h000, d});
            wr(REG_INDIRECT_WINDOW, a);
            rchk(REG_INDIRECT_WINDOW, a);
            wr(REG_INDIRECT_CONTROL, {2'(t), 9'h000, d});
            rchk(REG_INDIRECT_CONTROL, {2'(t), 9'h000, d});
            rchk(REG_INDIRECT_WINDOW, mmd_val(d, a));
            check({11'h000, rd_seen}, {11'h000, d, a});
            a = a + ((t == 2) ? 16'h0001 : 16'h0000);
            wr(REG_INDIRECT_WINDOW, w);
            check({11'h000, wr_seen}, {11'h000, d, a});
            check({16'h0000, wd_seen}, {16'h0000, w});
            wr(REG_INDIRECT_CONTROL, {ACC_ADDRESS, 9'h000, d});
            rchk(REG_INDIRECT_WINDOW, a + ((t == 1) ? 16'h0000 : 16'h0001));
        end
        wr(REG_INDIRECT_CONTROL, {ACC_ADDRESS, 9'h000, d2});
        rchk(REG_INDIRECT_WINDOW, b);
        end_of_test();
    end
endmodule : testbench

// >>> src/gige_mgmt_pkg.sv
// shared constants and types for the gigabit status and indirect access registers
package gige_mgmt_pkg;
    // register offsets on the management link
    localparam logic [4:0] REG_GIGABIT_LINK_STATUS = 5'h0a;
    localparam logic [4:0] REG_RSVD_POWER_CTRL = 5'h0b;
    localparam logic [4:0] REG_RSVD_POWER_STATUS = 5'h0c;
    localparam logic [4:0] REG_INDIRECT_CONTROL = 5'h0d;
    localparam logic [4:0] REG_INDIRECT_WINDOW = 5'h0e;
    localparam logic [4:0] REG_EXT_CAPABILITY = 5'h0f;

    // reset values
    localparam logic [15:0] GIGABIT_LINK_STATUS_RST = 16'h0000;
    localparam logic [15:0] RSVD_POWER_RST = 16'h0000;
    localparam logic [15:0] INDIRECT_CONTROL_RST = 16'h0000;
    localparam logic [15:0] INDIRECT_WINDOW_RST = 16'h0000;
    localparam logic [15:0] EXT_CAPABILITY_RST = 16'h3000;

    // gigabit_link_status field positions
    localparam int MS_FAULT_BIT = 15;
    localparam int MS_RESULT_BIT = 14;
    localparam int LOCAL_RX_OK_BIT = 13;
    localparam int REMOTE_RX_OK_BIT = 12;
    localparam int PARTNER_FD_BIT = 11;
    localparam int PARTNER_HD_BIT = 10;
    localparam int IDLE_ERR_MSB = 7;

    // indirect_access_control field positions
    localparam int ACCESS_TYPE_MSB = 15;
    localparam int ACCESS_TYPE_LSB = 14;
    localparam int DEVICE_NUM_MSB = 4;

    // master/slave resolution failures that raise the fault
    localparam logic [2:0] MS_FAIL_LIMIT = 3'h7;
    localparam logic [7:0] IDLE_ERR_MAX = 8'hff;

    // management frame layout
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] HEADER_BITS = 5'h0c;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [1:0] OPCODE_READ = 2'h2;
    localparam logic [1:0] OPCODE_WRITE = 2'h1;
    localparam int MMD_COUNT = 32;

    typedef enum logic [1:0] {
        ACC_ADDRESS = 2'b00,
        ACC_DATA = 2'b01,
        ACC_DATA_POST_INCREMENT = 2'b10,
        ACC_DATA_POST_INCREMENT_WR = 2'b11
    } access_type_t;

    typedef enum logic [2:0] {
        FR_PREAMBLE = 3'b000,
        FR_START = 3'b001,
        FR_HEADER = 3'b010,
        FR_TURN = 3'b011,
        FR_DATA = 3'b100
    } frame_state_t;

    // status from the physical-layer state machines, all on sys_clk
    typedef struct packed {
        logic ms_resolve_fail;   // pulse: one failed resolution attempt
        logic an_enable;         // pulse: auto-negotiation enabled
        logic an_complete;       // pulse: auto-negotiation complete
        logic ms_is_master;      // level: resolved to master
        logic local_rx_ok;       // level
        logic remote_rx_ok;      // level
        logic partner_fd;        // level: partner 1000t full duplex
        logic partner_hd;        // level: partner 1000t half duplex
        logic receiving_idle;    // level
        logic both_rx_ok_mode;   // level: transmit mode says both receivers ok
        logic rx_error_symbol;   // pulse: one symbol period with receive error
        logic pcs_reset;         // pulse: coding sublayer reset
    } phy_status_t;

    // request towards the selected mmd
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mmd_req_t;
endpackage : gige_mgmt_pkg

// >>> src/gige_status_mmd_access_regs.sv
// management registers 0x0a..0x0f with the serial management slave
`timescale 1ns/1ps

// Operation
// - fault flag latches high and clears on each status register read.
// - fault flag also clears on auto-negotiation enable or completion.
// - fault flag sets when failed master/slave resolutions reach seven.
// - bit 14 shows resolution result, one for master, zero for slave.
// - bit 13 shows local receiver ok.
// - bit 12 shows remote receiver ok.
// - bits 11 and 10 show partner 1000t full and half duplex ability.
// - bits 7:0 count idle errors only while both receivers are ok.
// - counter steps once per symbol period with receive error.
// - counter clears on status register read and coding sublayer reset.
// - counter saturates at all ones instead of wrapping.
// - registers 0x0b and 0x0c read zero; management writes zeros.
// - each mmd keeps its own address register.
// - window accesses go to the mmd named in control bits 4:0.
// - access type zero targets the selected mmd's address register.
// - plain data mode targets the pointed register, address unchanged.
// - post-increment mode bumps the address after each read or write.
// - write-only post-increment bumps after writes, not after reads.
// - window carries either the address or the pointed register content.
// - extended capability register is read-only; writes have no effect.
// - extended capability reports 1000x and 1000t abilities, resets to 0x3000.
module gige_status_mmd_access_regs
    import gige_mgmt_pkg::*;
(
    input wire logic sys_clk,            // 50 mhz system clock
    input wire logic resetn,             // async reset, active low
    input wire logic mdc,                // management clock from the station
    input wire logic mdio_i,             // management data in
    output logic mdio_o,                 // management data out
    output logic mdio_oe,                // high while driving mdio
    input wire logic [4:0] phy_addr,     // station address of this device
    input wire phy_status_t phy_status,  // status from the line side
    output mmd_req_t mmd_req,            // registered request to the mmds
    input wire logic [15:0] mmd_rdata    // content at mmd_req.dev/addr
);
    logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
    logic mdio_s1_r, mdio_s2_r;
    logic [4:0] phy_addr_s1_r, phy_addr_s2_r;
    logic bit_stb;

    frame_state_t state_r;
    logic [5:0] ones_r;
    logic [4:0] cnt_r;
    logic [11:0] hdr_r;
    logic [15:0] shift_r;
    logic is_read_r, mine_r;
    logic [4:0] regad_r;
    logic hdr_done, read_take, write_take, read_done;
    logic hdr_mine;

    logic ms_fault_r;
    logic [2:0] ms_fail_cnt_r;
    logic [7:0] idle_err_r;
    access_type_t acc_type_r;
    logic [4:0] dev_num_r;
    logic [15:0] mmd_addr_r [MMD_COUNT];
    logic [15:0] sel_addr;
    logic [15:0] rd_value;
    logic status_read;

    // pins and strap come from outside this clock's domain
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_s3_r <= 1'b0;
            mdio_s1_r <= 1'b1;
            mdio_s2_r <= 1'b1;
            phy_addr_s1_r <= 5'h00;
            phy_addr_s2_r <= 5'h00;
        end else begin
            mdc_s1_r <= mdc;
            mdc_s2_r <= mdc_s1_r;
            mdc_s3_r <= mdc_s2_r;
            mdio_s1_r <= mdio_i;
            mdio_s2_r <= mdio_s1_r;
            phy_addr_s1_r <= phy_addr;
            phy_addr_s2_r <= phy_addr_s1_r;
        end
    end

    assign bit_stb = mdc_s2_r & ~mdc_s3_r;

    assign hdr_mine = (hdr_r[9:5] == phy_addr_s2_r)
                   && (hdr_r[4:0] >= REG_GIGABIT_LINK_STATUS)
                   && ((hdr_r[11:10] == OPCODE_READ) || (hdr_r[11:10] == OPCODE_WRITE));
    assign hdr_done = bit_stb && (state_r == FR_HEADER) && (cnt_r == HEADER_BITS - 5'h01);
    // mine_r and regad_r only land at this strobe, so the take decodes the header itself
    assign read_take = bit_stb && (state_r == FR_TURN) && (cnt_r == 5'h00) && hdr_mine
                    && (hdr_r[11:10] == OPCODE_READ);
    assign write_take = bit_stb && (state_r == FR_DATA) && (cnt_r == DATA_BITS - 5'h01)
                     && mine_r && !is_read_r;
    assign read_done = bit_stb && (state_r == FR_DATA) && (cnt_r == DATA_BITS - 5'h01)
                    && mine_r && is_read_r;
    assign status_read = read_take && (hdr_r[4:0] == REG_GIGABIT_LINK_STATUS);

    // frame sequencing: preamble, start, header, turnaround, data
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= FR_PREAMBLE;
            ones_r <= 6'h00;
            cnt_r <= 5'h00;
            hdr_r <= 12'h000;
            is_read_r <= 1'b0;
            mine_r <= 1'b0;
            regad_r <= 5'h00;
        end else if (bit_stb) begin
            case (state_r)
                FR_PREAMBLE: begin
                    if (mdio_s2_r) begin
                        if (ones_r != PREAMBLE_ONES) begin
                            ones_r <= ones_r + 6'h01;
                        end
                    end else if (ones_r == PREAMBLE_ONES) begin
                        state_r <= FR_START;
                        ones_r <= 6'h00;
                    end else begin
                        ones_r <= 6'h00;
                    end
                end
                FR_START: begin
                    state_r <= mdio_s2_r ? FR_HEADER : FR_PREAMBLE;
                    cnt_r <= 5'h00;
                end
                FR_HEADER: begin
                    hdr_r <= {hdr_r[10:0], mdio_s2_r};
                    cnt_r <= cnt_r + 5'h01;
                    if (hdr_done) begin
                        state_r <= FR_TURN;
                        cnt_r <= 5'h00;
                    end
                end
                FR_TURN: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == 5'h00) begin
                        // full header is in hdr_r by now
                        mine_r <= hdr_mine;
                        is_read_r <= (hdr_r[11:10] == OPCODE_READ);
                        regad_r <= hdr_r[4:0];
                    end else begin
                        state_r <= FR_DATA;
                        cnt_r <= 5'h00;
                    end
                end
                FR_DATA: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == DATA_BITS - 5'h01) begin
                        state_r <= FR_PREAMBLE;
                        mine_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= FR_PREAMBLE;
                end
            endcase
        end
    end

    assign sel_addr = mmd_addr_r[dev_num_r];

    // read mux; hdr_r holds the register number at the take
    always_comb begin
        rd_value = 16'h0000;
        if (hdr_r[4:0] == REG_GIGABIT_LINK_STATUS) begin
            rd_value[MS_FAULT_BIT] = ms_fault_r;
            rd_value[MS_RESULT_BIT] = phy_status.ms_is_master;
            rd_value[LOCAL_RX_OK_BIT] = phy_status.local_rx_ok;
            rd_value[REMOTE_RX_OK_BIT] = phy_status.remote_rx_ok;
            rd_value[PARTNER_FD_BIT] = phy_status.partner_fd;
            rd_value[PARTNER_HD_BIT] = phy_status.partner_hd;
            rd_value[IDLE_ERR_MSB:0] = idle_err_r;
        end else if (hdr_r[4:0] == REG_RSVD_POWER_CTRL) begin
            rd_value = RSVD_POWER_RST;
        end else if (hdr_r[4:0] == REG_RSVD_POWER_STATUS) begin
            rd_value = RSVD_POWER_RST;
        end else if (hdr_r[4:0] == REG_INDIRECT_CONTROL) begin
            rd_value[ACCESS_TYPE_MSB:ACCESS_TYPE_LSB] = acc_type_r;
            rd_value[DEVICE_NUM_MSB:0] = dev_num_r;
        end else if (hdr_r[4:0] == REG_INDIRECT_WINDOW) begin
            // address or pointed content, by access type
            rd_value = (acc_type_r == ACC_ADDRESS) ? sel_addr : mmd_rdata;
        end else if (hdr_r[4:0] == REG_EXT_CAPABILITY) begin
            rd_value = EXT_CAPABILITY_RST;
        end
    end

    // data shifter and pin drive; turnaround bit two is driven low
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shift_r <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (bit_stb) begin
            if (read_take) begin
                shift_r <= rd_value;
                mdio_o <= 1'b0;
                mdio_oe <= 1'b1;
            end else if (state_r == FR_TURN && cnt_r != 5'h00 && mine_r && is_read_r) begin
                mdio_o <= shift_r[15];
                shift_r <= {shift_r[14:0], 1'b0};
            end else if (state_r == FR_DATA && cnt_r != DATA_BITS - 5'h01) begin
                if (mine_r && is_read_r) begin
                    mdio_o <= shift_r[15];
                    shift_r <= {shift_r[14:0], 1'b0};
                end else begin
                    shift_r <= {shift_r[14:0], mdio_s2_r};
                end
            end else begin
                if (state_r == FR_DATA) begin
                    shift_r <= {shift_r[14:0], mdio_s2_r};
                end
                mdio_o <= 1'b0;
                mdio_oe <= 1'b0;
            end
        end
    end

    // master/slave fault: set beats any clear in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ms_fail_cnt_r <= 3'h0;
            ms_fault_r <= 1'b0;
        end else begin
            if (phy_status.an_enable || phy_status.an_complete) begin
                ms_fail_cnt_r <= 3'h0;
            end else if (phy_status.ms_resolve_fail && ms_fail_cnt_r != MS_FAIL_LIMIT) begin
                ms_fail_cnt_r <= ms_fail_cnt_r + 3'h1;
            end
            if (phy_status.ms_resolve_fail
                && (ms_fail_cnt_r >= MS_FAIL_LIMIT - 3'h1)) begin
                ms_fault_r <= 1'b1;
            end else if (status_read) begin
                ms_fault_r <= 1'b0;
            end else if (phy_status.an_enable || phy_status.an_complete) begin
                ms_fault_r <= 1'b0;
            end
        end
    end

    // idle error counter; an error in the read cycle survives as one count
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            idle_err_r <= 8'h00;
        end else if (phy_status.pcs_reset) begin
            idle_err_r <= 8'h00;
        end else if (phy_status.rx_error_symbol && phy_status.receiving_idle
                     && phy_status.both_rx_ok_mode) begin
            if (status_read) begin
                idle_err_r <= 8'h01;
            end else if (idle_err_r != IDLE_ERR_MAX) begin
                idle_err_r <= idle_err_r + 8'h01;
            end
        end else if (status_read) begin
            idle_err_r <= 8'h00;
        end
    end

    // control register; writes to status, reserved and capability are dropped
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc_type_r <= ACC_ADDRESS;
            dev_num_r <= 5'h00;
        end else if (write_take && regad_r == REG_INDIRECT_CONTROL) begin
            acc_type_r <= access_type_t'(shift_r[ACCESS_TYPE_MSB - 1:ACCESS_TYPE_LSB - 1]);
            dev_num_r <= {shift_r[DEVICE_NUM_MSB - 1:0], mdio_s2_r};
        end
    end

    // one address register per mmd
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < MMD_COUNT; i++) begin
                mmd_addr_r[i] <= INDIRECT_WINDOW_RST;
            end
        end else if (write_take && regad_r == REG_INDIRECT_WINDOW) begin
            if (acc_type_r == ACC_ADDRESS) begin
                mmd_addr_r[dev_num_r] <= {shift_r[14:0], mdio_s2_r};
            end else if (acc_type_r != ACC_DATA) begin
                mmd_addr_r[dev_num_r] <= sel_addr + 16'h0001;
            end
        end else if (read_done && regad_r == REG_INDIRECT_WINDOW
                     && acc_type_r == ACC_DATA_POST_INCREMENT) begin
            mmd_addr_r[dev_num_r] <= sel_addr + 16'h0001;
        end
    end

    // request to the selected mmd, address taken before any increment
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mmd_req <= '0;
        end else begin
            mmd_req.dev <= dev_num_r;
            mmd_req.addr <= sel_addr;
            mmd_req.rd <= read_take && hdr_r[4:0] == REG_INDIRECT_WINDOW
                          && acc_type_r != ACC_ADDRESS;
            mmd_req.wr <= write_take && regad_r == REG_INDIRECT_WINDOW
                          && acc_type_r != ACC_ADDRESS;
            if (write_take) begin
                mmd_req.wdata <= {shift_r[14:0], mdio_s2_r};
            end
        end
    end
endmodule : gige_status_mmd_access_regs
